//--- hdl/ppf_pkg.sv
package ppf_pkg;
   // port widths
   localparam int PORT_B_W = 8;
   localparam int PORT_C_W = 7;
   localparam int PORT_D_W = 8;
   // port c bit that doubles as the reset input
   localparam int PC_RST_BIT = 6;
   // port b bits that double as oscillator pins
   localparam int PB_OSC_IN_BIT = 6;
   localparam int PB_OSC_OUT_BIT = 7;
   // fuse encoding: one is unprogrammed, zero is programmed
   localparam logic FUSE_PROG = 1'h0;
   localparam logic FUSE_UNPROG = 1'h1;
   // clock-select fuse width and codes
   localparam int CKSEL_W = 4;
   localparam logic [3:0] CKSEL_RC_CAL = 4'h2;
   localparam logic [3:0] CKSEL_XTAL_LO = 4'h4;
   // clock period and least reset pulse on the reset pin
   localparam int CLK_PERIOD_NS = 4;
   localparam int RST_PULSE_NS = 2500;
   localparam int RST_PULSE_CYC =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // apb register byte addresses
   localparam logic [7:0] ADDR_PORTB_OUT = 8'h00;
   localparam logic [7:0] ADDR_PORTB_DIR = 8'h04;
   localparam logic [7:0] ADDR_PORTB_IN = 8'h08;
   localparam logic [7:0] ADDR_PORTC_OUT = 8'h0C;
   localparam logic [7:0] ADDR_PORTC_DIR = 8'h10;
   localparam logic [7:0] ADDR_PORTC_IN = 8'h14;
   localparam logic [7:0] ADDR_PORTD_OUT = 8'h18;
   localparam logic [7:0] ADDR_PORTD_DIR = 8'h1C;
   localparam logic [7:0] ADDR_PORTD_IN = 8'h20;
   localparam logic [7:0] ADDR_ASYNC_CTRL = 8'h24;
   localparam logic [7:0] ADDR_FUNC_STAT = 8'h28;
   // field positions
   localparam int ASYNC_SEL_BIT = 0;
   localparam int STAT_XTAL_BIT = 0;
   localparam int STAT_TOSC_BIT = 1;
   localparam int STAT_RSTIO_BIT = 2;
   localparam int STAT_PINRST_BIT = 3;
   // reset values
   localparam logic [31:0] REG_RST = 32'h0;
endpackage

//--- hdl/ppf_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_port_mux
   import ppf_pkg::*;
#(
   parameter int RST_CYCLES = RST_PULSE_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CKSEL_W-1:0] clock_select_fuse,
   input wire logic reset_pin_disable_fuse,
   input wire logic [PORT_B_W-1:0] port_b_bits_in,
   output logic [PORT_B_W-1:0] port_b_bits_out,
   output logic [PORT_B_W-1:0] port_b_bits_oe,
   output logic [PORT_B_W-1:0] port_b_pullup,
   input wire logic [PORT_C_W-1:0] port_c_bits_in,
   output logic [PORT_C_W-1:0] port_c_bits_out,
   output logic [PORT_C_W-1:0] port_c_bits_oe,
   output logic [PORT_C_W-1:0] port_c_pullup,
   input wire logic [PORT_D_W-1:0] port_d_bits_in,
   output logic [PORT_D_W-1:0] port_d_bits_out,
   output logic [PORT_D_W-1:0] port_d_bits_oe,
   output logic [PORT_D_W-1:0] port_d_pullup,
   output logic osc_amp_in,
   output logic osc_amp_in_valid,
   output logic timer_oscillator_pins_en,
   output logic pin_reset_req
);
   // low counter is sixteen bits; refuse lengths it cannot hold
   if (RST_CYCLES < 1 || RST_CYCLES > 65535)
   begin
      $error("RST_CYCLES out of range");
   end

   // software registers: output value and direction per port
   logic [PORT_B_W-1:0] b_out;
   logic [PORT_B_W-1:0] b_dir;
   logic [PORT_C_W-1:0] c_out;
   logic [PORT_C_W-1:0] c_dir;
   logic [PORT_D_W-1:0] d_out;
   logic [PORT_D_W-1:0] d_dir;
   // timer clock select bit
   logic async_timer_clock_select;
   // latched fuse functions
   logic xtal_mode;
   logic rc_mode;
   logic rst_pin_io;
   logic fuse_loaded;
   // input synchronisers, three stages each
   logic [PORT_B_W-1:0] b_s1, b_s2, b_s3, b_sync;
   logic [PORT_C_W-1:0] c_s1, c_s2, c_s3, c_sync;
   logic [PORT_D_W-1:0] d_s1, d_s2, d_s3, d_sync;
   // reset pin low counter
   logic [15:0] low_cnt;
   logic wr_en;
   logic rd_en;

   // true for a fuse bit that is programmed
   function automatic logic fuse_is_prog(input logic f);
      return f == FUSE_PROG;
   endfunction

   // crystal codes: anything other than rc, 128k rc, external
   function automatic logic is_xtal(input logic [CKSEL_W-1:0] s);
      return s >= CKSEL_XTAL_LO;
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // fuse functions caught once after reset release, then held
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_loaded <= 1'b0;
         xtal_mode <= 1'b0;
         rc_mode <= 1'b0;
         rst_pin_io <= 1'b0;
      end
      else if (!fuse_loaded)
      begin
         fuse_loaded <= 1'b1;
         xtal_mode <= is_xtal(clock_select_fuse);
         rc_mode <= clock_select_fuse == CKSEL_RC_CAL;
         rst_pin_io <= fuse_is_prog(reset_pin_disable_fuse);
      end
   end

   // register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         b_out <= '0;
         b_dir <= '0;
         c_out <= '0;
         c_dir <= '0;
         d_out <= '0;
         d_dir <= '0;
         async_timer_clock_select <= 1'b0;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            ADDR_PORTB_OUT: b_out <= pwdata[PORT_B_W-1:0];
            ADDR_PORTB_DIR: b_dir <= pwdata[PORT_B_W-1:0];
            ADDR_PORTC_OUT: c_out <= pwdata[PORT_C_W-1:0];
            ADDR_PORTC_DIR: c_dir <= pwdata[PORT_C_W-1:0];
            ADDR_PORTD_OUT: d_out <= pwdata[PORT_D_W-1:0];
            ADDR_PORTD_DIR: d_dir <= pwdata[PORT_D_W-1:0];
            ADDR_ASYNC_CTRL:
               async_timer_clock_select <= pwdata[ASYNC_SEL_BIT];
            default: ;
         endcase
      end
   end

   // pin synchronisers; second and third stages must agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {b_s1, b_s2, b_s3, b_sync} <= '0;
         {c_s1, c_s2, c_s3} <= '1; // idle high: no false low at release
         c_sync <= '1;
         {d_s1, d_s2, d_s3, d_sync} <= '0;
      end
      else
      begin
         b_s1 <= port_b_bits_in;
         b_s2 <= b_s1;
         b_s3 <= b_s2;
         c_s1 <= port_c_bits_in;
         c_s2 <= c_s1;
         c_s3 <= c_s2;
         d_s1 <= port_d_bits_in;
         d_s2 <= d_s1;
         d_s3 <= d_s2;
         for (int i = 0; i < PORT_B_W; i++)
            if (b_s2[i] == b_s3[i])
               b_sync[i] <= b_s3[i];
         for (int i = 0; i < PORT_C_W; i++)
            if (c_s2[i] == c_s3[i])
               c_sync[i] <= c_s3[i];
         for (int i = 0; i < PORT_D_W; i++)
            if (d_s2[i] == d_s3[i])
               d_sync[i] <= d_s3[i];
      end
   end

   // reset pin: count cycles low, request reset past the least pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_cnt <= '0;
         pin_reset_req <= 1'b0;
      end
      else if (fuse_loaded && !rst_pin_io && !c_sync[PC_RST_BIT])
      begin
         if (low_cnt < 16'(RST_CYCLES))
            low_cnt <= low_cnt + 16'h0001;
         pin_reset_req <= low_cnt >= 16'(RST_CYCLES - 1);
      end
      else
      begin
         low_cnt <= '0;
         pin_reset_req <= 1'b0;
      end
   end

   // pad drivers; asynchronous reset tri-states every pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_bits_oe <= '0;
         port_b_bits_out <= '0;
         port_b_pullup <= '0;
         port_c_bits_oe <= '0;
         port_c_bits_out <= '0;
         port_c_pullup <= '0;
         port_d_bits_oe <= '0;
         port_d_bits_out <= '0;
         port_d_pullup <= '0;
         timer_oscillator_pins_en <= 1'b0;
         osc_amp_in <= 1'b0;
         osc_amp_in_valid <= 1'b0;
      end
      else
      begin
         // pull-up on input bits whose output latch is one
         port_b_bits_oe <= b_dir;
         port_b_bits_out <= b_out;
         port_b_pullup <= ~b_dir & b_out;
         port_c_bits_oe <= c_dir;
         port_c_bits_out <= c_out;
         port_c_pullup <= ~c_dir & c_out;
         port_d_bits_oe <= d_dir;
         port_d_bits_out <= d_out;
         port_d_pullup <= ~d_dir & d_out;
         timer_oscillator_pins_en <= 1'b0;
         osc_amp_in <= 1'b0;
         osc_amp_in_valid <= 1'b0;
         if (!fuse_loaded)
         begin
            port_b_bits_oe <= '0;
            port_c_bits_oe <= '0;
            port_d_bits_oe <= '0;
         end
         else if (xtal_mode)
         begin
            // bit six feeds the amplifier, bit seven is its output
            port_b_bits_oe[PB_OSC_IN_BIT] <= 1'b0;
            port_b_pullup[PB_OSC_IN_BIT] <= 1'b0;
            osc_amp_in <= b_sync[PB_OSC_IN_BIT];
            osc_amp_in_valid <= 1'b1;
            port_b_bits_oe[PB_OSC_OUT_BIT] <= 1'b1;
            port_b_bits_out[PB_OSC_OUT_BIT] <= ~b_sync[PB_OSC_IN_BIT];
            port_b_pullup[PB_OSC_OUT_BIT] <= 1'b0;
         end
         else if (rc_mode && async_timer_clock_select)
         begin
            // both pins handed to the timer oscillator
            port_b_bits_oe[PB_OSC_OUT_BIT] <= 1'b0;
            port_b_bits_oe[PB_OSC_IN_BIT] <= 1'b0;
            port_b_pullup[PB_OSC_OUT_BIT] <= 1'b0;
            port_b_pullup[PB_OSC_IN_BIT] <= 1'b0;
            timer_oscillator_pins_en <= 1'b1;
         end
         if (fuse_loaded && !rst_pin_io)
         begin
            // reset input: never driven, pull-up held on
            port_c_bits_oe[PC_RST_BIT] <= 1'b0;
            port_c_pullup[PC_RST_BIT] <= 1'b1;
         end
      end
   end

   // apb read data and answer; unmapped addresses flag an error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= REG_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata <= REG_RST;
            unique case (paddr)
               ADDR_PORTB_OUT: prdata <= 32'(b_out);
               ADDR_PORTB_DIR: prdata <= 32'(b_dir);
               ADDR_PORTB_IN: prdata <= 32'(b_sync);
               ADDR_PORTC_OUT: prdata <= 32'(c_out);
               ADDR_PORTC_DIR: prdata <= 32'(c_dir);
               ADDR_PORTC_IN: prdata <= 32'(c_sync);
               ADDR_PORTD_OUT: prdata <= 32'(d_out);
               ADDR_PORTD_DIR: prdata <= 32'(d_dir);
               ADDR_PORTD_IN: prdata <= 32'(d_sync);
               ADDR_ASYNC_CTRL:
                  prdata <= 32'(async_timer_clock_select);
               ADDR_FUNC_STAT:
                  prdata <= 32'({pin_reset_req, rst_pin_io,
                     timer_oscillator_pins_en, xtal_mode});
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // port b and c pins stay tri-stated while reset is low
   reset_tristate_a: assert property (@(posedge pclk)
      !presetn |-> (port_b_bits_oe == '0 && port_c_bits_oe == '0))
      else $error("port driven during reset");
   // crystal mode drives bit seven, never bit six
   xtal_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded && xtal_mode |=> port_b_bits_oe[PB_OSC_OUT_BIT]
      && !port_b_bits_oe[PB_OSC_IN_BIT])
      else $error("crystal pins misdriven");
   // bit seven is the inverse of bit six in crystal mode
   xtal_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded && xtal_mode |=> port_b_bits_out[PB_OSC_OUT_BIT]
      == !$past(b_sync[PB_OSC_IN_BIT]))
      else $error("oscillator output wrong");
   // timer pins freed when rc clock and select set
   timer_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded && rc_mode && async_timer_clock_select |=>
      timer_oscillator_pins_en && !port_b_bits_oe[PB_OSC_OUT_BIT])
      else $error("timer pins not freed");
   // reset pin never driven when it is the reset input
   reset_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded && !rst_pin_io |=> !port_c_bits_oe[PC_RST_BIT])
      else $error("reset pin driven");
   // pin reset only after a low stretch of the least length
   pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pin_reset_req) |-> !$past(c_sync[PC_RST_BIT]) && !rst_pin_io
      && low_cnt == 16'(RST_CYCLES))
      else $error("pin reset without low level");
   // fuse functions do not change once latched
   fuse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded |=> $stable(xtal_mode) && $stable(rst_pin_io)
      && $stable(rc_mode))
      else $error("fuse function changed");
   // programmed reset-disable fuse makes the pin plain io
   fuse_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(fuse_loaded) |-> rst_pin_io == !$past(reset_pin_disable_fuse))
      else $error("fuse polarity wrong");
   // pull-ups follow register on plain port d
   pullup_d_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded |=> port_d_pullup == ($past(d_out) & ~$past(d_dir)))
      else $error("port d pull-up wrong");
   // port b pull-ups on plain bits follow register
   pullup_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded && !xtal_mode && !rc_mode |=>
      port_b_pullup == ($past(b_out) & ~$past(b_dir)))
      else $error("port b pull-up wrong");
   // port c low bits follow direction register
   dir_c_a: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_loaded |=> port_c_bits_oe[5:0] == $past(c_dir[5:0]))
      else $error("port c direction wrong");
endmodule
`default_nettype wire

//--- tb/ppf_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// board around the ports: design drive wins, then an outside driver,
// then the pull-up; an undriven pin with no pull-up wanders each cycle
module ppf_board_model
   import ppf_pkg::*;
(
   input wire logic pclk,
   input wire logic [7:0] b_out,
   input wire logic [7:0] b_oe,
   input wire logic [7:0] b_pu,
   input wire logic [6:0] c_out,
   input wire logic [6:0] c_oe,
   input wire logic [6:0] c_pu,
   input wire logic [7:0] d_out,
   input wire logic [7:0] d_oe,
   input wire logic [7:0] d_pu,
   input wire logic [7:0] xb_en,
   input wire logic [7:0] xb_val,
   input wire logic [6:0] xc_en,
   input wire logic [6:0] xc_val,
   output logic [7:0] b_pad,
   output logic [6:0] c_pad,
   output logic [7:0] d_pad
);
   // float pattern, flipped every clock so no stale level survives
   logic [7:0] flt = 8'h55;
   // port c levels before trimming to seven bits
   logic [7:0] c_lvl;
   // flips the floating pattern
   always @(posedge pclk)
   begin
      flt <= ~flt;
   end
   // level of each pin from all parties on it
   // float pattern passed in so the pads follow each flip
   function automatic logic [7:0] lvl(input logic [7:0] o, e, u, xe, xv, f);
      for (int i = 0; i < 8; i++)
      begin
         lvl[i] = e[i] ? o[i] : (xe[i] ? xv[i] : (u[i] ? 1'b1 : f[i]));
      end
   endfunction
   assign b_pad = lvl(b_out, b_oe, b_pu, xb_en, xb_val, flt);
   assign c_lvl = lvl({1'b0, c_out}, {1'b0, c_oe}, {1'b0, c_pu},
      {1'b0, xc_en}, {1'b0, xc_val}, flt);
   assign c_pad = c_lvl[6:0];
   assign d_pad = lvl(d_out, d_oe, d_pu, 8'h00, 8'h00, flt);
endmodule
`default_nettype wire

//--- tb/test_port_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_select
   import ppf_pkg::*;
;
   // one register walk: out address, direction, value, expected pads
   typedef struct {
      logic [7:0] oa;
      logic [31:0] dir;
      logic [31:0] val;
      logic [31:0] exp;
   } ppf_row_t;
   ppf_row_t rows [6] = '{'{8'h00, 32'hFF, 32'hA5, 32'hA5},
      '{8'h00, 32'h00, 32'hFF, 32'hFF}, '{8'h0C, 32'h7F, 32'h2A, 32'h2A},
      '{8'h0C, 32'h00, 32'h7F, 32'h7F}, '{8'h18, 32'hFF, 32'hC3, 32'hC3},
      '{8'h18, 32'h0F, 32'hF0, 32'hF0}};
   logic pclk = 1'b0;
   logic clk_run = 1'b1;
   logic presetn, psel, penable, pwrite, pready, pslverr, er_v, seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [3:0] clock_select_fuse;
   logic reset_pin_disable_fuse;
   logic [7:0] b_pad, b_out, b_oe, b_pu, d_pad, d_out, d_oe, d_pu;
   logic [6:0] c_pad, c_out, c_oe, c_pu, xc_en, xc_val;
   logic [7:0] xb_en, xb_val;
   logic osc_in, osc_ok, tosc_en, prst_req;
   int error_cnt = 0;
   int comparisons = 0;
   // clock, can be stopped for the clockless reset case
   always
   begin
      #2;
      if (clk_run) pclk = ~pclk;
   end
   ppf_port_mux #(.RST_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_select_fuse(clock_select_fuse),
      .reset_pin_disable_fuse(reset_pin_disable_fuse),
      .port_b_bits_in(b_pad), .port_b_bits_out(b_out),
      .port_b_bits_oe(b_oe), .port_b_pullup(b_pu),
      .port_c_bits_in(c_pad), .port_c_bits_out(c_out),
      .port_c_bits_oe(c_oe), .port_c_pullup(c_pu),
      .port_d_bits_in(d_pad), .port_d_bits_out(d_out),
      .port_d_bits_oe(d_oe), .port_d_pullup(d_pu), .osc_amp_in(osc_in),
      .osc_amp_in_valid(osc_ok), .timer_oscillator_pins_en(tosc_en),
      .pin_reset_req(prst_req));
   ppf_board_model board_u (.pclk(pclk), .b_out(b_out), .b_oe(b_oe),
      .b_pu(b_pu), .c_out(c_out), .c_oe(c_oe), .c_pu(c_pu),
      .d_out(d_out), .d_oe(d_oe), .d_pu(d_pu), .xb_en(xb_en),
      .xb_val(xb_val), .xc_en(xc_en), .xc_val(xc_val), .b_pad(b_pad),
      .c_pad(c_pad), .d_pad(d_pad));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is seen
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) error_cnt++;
      rd_v = prdata;
      er_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // register read with compare
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd_v, exp);
   endtask
   // reset with the given fuses, released at a clock edge
   task automatic boot(input logic [3:0] cs, input logic rp);
      clk_run = 1'b1;
      presetn <= 1'b0;
      clock_select_fuse <= cs;
      reset_pin_disable_fuse <= rp;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // pads settle at the second edge; look after the third
      repeat (3) @(posedge pclk);
   endtask
   // counts and verdict
   task automatic summarize();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // cuts a hang short
   initial
   begin
      #100000;
      error_cnt++;
      summarize();
   end
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {xb_en, xb_val, xc_en, xc_val} = '0;
      clock_select_fuse = 4'h0;
      reset_pin_disable_fuse = FUSE_PROG;
      boot(4'h0, FUSE_PROG);
      rdc(ADDR_PORTB_OUT, REG_RST);
      rdc(8'h2C, 32'h0);
      chk({31'h0, er_v}, 32'h1);
      foreach (rows[i])
      begin
         xfer(1'b1, rows[i].oa + 8'h04, rows[i].dir);
         xfer(1'b1, rows[i].oa, rows[i].val);
         repeat (6) @(posedge pclk);
         rdc(rows[i].oa + 8'h08, rows[i].exp);
      end
      // port c bit six held low while it is plain io
      xc_en <= 7'h40;
      repeat (20) @(posedge pclk);
      chk({31'h0, prst_req}, 32'h0);
      xc_en <= 7'h00;
      rdc(ADDR_FUNC_STAT, 32'h4);
      xfer(1'b1, ADDR_ASYNC_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      chk({31'h0, tosc_en}, 32'h0);
      // reset while the clock stands still
      clk_run = 1'b0;
      presetn <= 1'b0;
      #10;
      chk({9'h0, b_oe, c_oe, d_oe}, 32'h0);
      chk({9'h0, b_out, c_out, d_out}, 32'h0);
      boot(CKSEL_XTAL_LO, FUSE_UNPROG);
      chk({31'h0, osc_ok}, 32'h1);
      xb_en <= 8'h40;
      xb_val <= 8'h40;
      repeat (8) @(posedge pclk);
      chk({31'h0, osc_in}, 32'h1);
      chk({31'h0, b_out[PB_OSC_OUT_BIT]}, 32'h0);
      xb_val <= 8'h00;
      repeat (8) @(posedge pclk);
      chk({31'h0, osc_in}, 32'h0);
      chk({31'h0, b_out[PB_OSC_OUT_BIT]}, 32'h1);
      xb_en <= 8'h00;
      rdc(ADDR_FUNC_STAT, 32'h1);
      clock_select_fuse <= CKSEL_RC_CAL;
      repeat (4) @(posedge pclk);
      rdc(ADDR_FUNC_STAT, 32'h1);
      // short low pulse on the reset pin must not trigger
      xc_en <= 7'h40;
      repeat (2) @(posedge pclk);
      xc_en <= 7'h00;
      seen = 1'b0;
      repeat (12)
      begin
         @(posedge pclk);
         seen = seen | prst_req;
      end
      chk({31'h0, seen}, 32'h0);
      xc_en <= 7'h40;
      repeat (20) @(posedge pclk);
      chk({31'h0, prst_req}, 32'h1);
      rdc(ADDR_FUNC_STAT, 32'h9);
      xc_en <= 7'h00;
      repeat (8) @(posedge pclk);
      chk({31'h0, prst_req}, 32'h0);
      boot(CKSEL_RC_CAL, FUSE_UNPROG);
      chk({31'h0, osc_ok}, 32'h0);
      xfer(1'b1, ADDR_ASYNC_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      chk({31'h0, tosc_en}, 32'h1);
      rdc(ADDR_FUNC_STAT, 32'h2);
      summarize();
   end
endmodule
`default_nettype wire
